/* File: design/swc_base_div.sv */
/*
 * Divider giving a one-cycle enable once per base clock period.
 * Assumes the 10 MHz system clock of the package.
 */
`timescale 1ns/1ps
`default_nettype none

module swc_base_div (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic tick
);
  import swc_pkg::*;

  swc_div_t r;
  swc_div_t r_nxt;

  always_comb begin
    r_nxt      = r;
    r_nxt.tick = 1'b0;
    if (r.cnt == swc_div_cnt_t'(BASE_DIV - 1)) begin
      r_nxt.cnt  = '0;
      r_nxt.tick = 1'b1;
    end else begin
      r_nxt.cnt = r.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign tick = r.tick;

endmodule : swc_base_div

`default_nettype wire

/* File: design/swc_config_port.sv */
/*
 * Single-wire configuration port: power-on reset hold, default loading,
 * reset marker, start pulse classification and 15-bit mode word
 * programming with equivalence acknowledge, plus a small register port.
 * Assumes an external pull-up on the open-drain data line and a supply
 * comparator level on SUPPLY_OK.
 */
// The strobed register port and the register offsets were left to the implementer.
// What this block does
// - power-on reset loads all register defaults
// - hold reset minimum period after supply recovery
// - after reset, drive 50% marker square wave
// - qualifying start pulse cancels the marker
// - marker frequency below any data frequency
// - start pulse released, device takes line
// - delay, then fifteen sync low pulses
// - window delay, window length, fixed bit frame
// - low in window stores 0, else 1
// - acknowledge pulse only when word unchanged
// - programming accepted in sleep or active
// - receive path disabled while programming
// - first bit one means poll command
// - short pulse ignored while marker runs
// - long pulse: start, defaults, cancel marker
// - limit defaults 21 and 41
// - sleep count default 6, factor 1
`timescale 1ns/1ps
`default_nettype none

module swc_config_port #(
  parameter swc_pkg::swc_cnt_t SHORT_START_TICKS = swc_pkg::SHORT_START_T,
  parameter swc_pkg::swc_cnt_t LONG_START_TICKS  = swc_pkg::LONG_START_T,
  parameter swc_pkg::swc_cnt_t MARKER_HALF_TICKS = swc_pkg::MARKER_HALF_T
) (
  input  wire logic               CLOCK,
  input  wire logic               RST_N,
  input  wire logic               DATA_I,
  input  wire logic               SUPPLY_OK,
  input  wire swc_pkg::swc_addr_t ADDR,
  input  wire logic [31:0]        WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output var  logic [31:0]        RDATA,
  output var  swc_pkg::swc_line_t DATA_DRV,
  output var  logic               RX_OFF,
  output var  logic               POLL_CMD,
  output var  swc_pkg::swc_word_t MODE_WORD,
  output var  swc_pkg::swc_lim_t  LIM_MIN,
  output var  swc_pkg::swc_lim_t  LIM_MAX,
  output var  logic               MARKER_ON,
  output var  logic               POR_ACTIVE
);
  import swc_pkg::*;

  swc_regs_t r;
  swc_regs_t r_nxt;
  logic      tick;
  logic      data_lvl;
  logic      supply_lvl;
  logic      line_low;
  logic      long_rel;
  logic      short_rel;

  function automatic logic phase_end(input swc_cnt_t c, input swc_cnt_t len,
                                     input logic tk);
    return tk && (c == swc_cnt_t'(len - 14'h0001));
  endfunction : phase_end

  swc_base_div u_div (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .tick  (tick)
  );

  swc_pin_sync u_data_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .pin   (DATA_I),
    .lvl   (data_lvl)
  );

  swc_pin_sync u_supply_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .pin   (SUPPLY_OK),
    .lvl   (supply_lvl)
  );

  assign line_low  = !data_lvl;
  assign long_rel  = r.lowcnt > LONG_START_TICKS;
  assign short_rel = (r.lowcnt > START_MIN_T) &&
                     (r.lowcnt < SHORT_START_TICKS);

  always_comb begin
    r_nxt         = r;
    r_nxt.poll    = 1'b0;
    r_nxt.rdata   = '0;
    r_nxt.was_low = line_low;

    // register port
    if (WR && ADDR == REG_LIMIT) begin
      r_nxt.lim_min = WDATA[5:0];
      r_nxt.lim_max = WDATA[LIM_MAX_LSB +: 6];
    end
    if (RD) begin
      case (ADDR)
        REG_MODE:   r_nxt.rdata = {17'h00000, r.mode};
        REG_LIMIT:  r_nxt.rdata = {20'h00000, r.lim_max, r.lim_min};
        REG_STATUS: r_nxt.rdata = {28'h0000000, r.eq, r.state != S_IDLE,
                                   r.marker, r.por};
        default:    r_nxt.rdata = '0;
      endcase
    end

    // supply monitor and reset hold
    if (!supply_lvl) begin
      r_nxt.por  = 1'b1;
      r_nxt.pcnt = '0;
    end else if (r.por && tick) begin
      if (phase_end(r.pcnt, swc_cnt_t'(RST_PERIOD_T + 14'h0001),
                    tick)) begin
        r_nxt.por  = 1'b0;
        r_nxt.pcnt = '0;
      end else begin
        r_nxt.pcnt = r.pcnt + 14'h0001;
      end
    end

    if (r.state != S_IDLE && tick) begin
      r_nxt.tcnt = r.tcnt + 14'h0001;
    end

    if (r_nxt.por) begin
      r_nxt.mode    = MODE_DEFAULT;
      r_nxt.lim_min = LIM_MIN_DEFAULT;
      r_nxt.lim_max = LIM_MAX_DEFAULT;
      r_nxt.marker  = 1'b1;
      r_nxt.mph     = 1'b0;
      r_nxt.state   = S_IDLE;
      r_nxt.lowcnt  = '0;
      r_nxt.tcnt    = '0;
    end else begin
      unique case (r.state)
        S_IDLE: begin
          // marker half periods, only once the reset hold is over
          if (r.marker && !r.por && tick) begin
            if (phase_end(r.pcnt, MARKER_HALF_TICKS, tick)) begin
              r_nxt.mph  = !r.mph;
              r_nxt.pcnt = '0;
            end else begin
              r_nxt.pcnt = r.pcnt + 14'h0001;
            end
          end
          if (line_low && tick && r.lowcnt != 14'h3fff) begin
            r_nxt.lowcnt = r.lowcnt + 14'h0001;
          end
          // classify on release; no sleep/active gating here
          if (r.was_low && !line_low) begin
            r_nxt.lowcnt = '0;
            if (long_rel) begin
              r_nxt.mode    = MODE_DEFAULT;
              r_nxt.lim_min = LIM_MIN_DEFAULT;
              r_nxt.lim_max = LIM_MAX_DEFAULT;
              r_nxt.marker  = 1'b0;
              r_nxt.mph     = 1'b0;
              r_nxt.pcnt    = '0;
              r_nxt.state   = S_DELAY;
              r_nxt.tcnt    = '0;
              r_nxt.bitn    = '0;
            end else if (short_rel && !r.marker) begin
              r_nxt.state = S_DELAY;
              r_nxt.tcnt  = '0;
              r_nxt.bitn  = '0;
            end
          end
        end
        S_DELAY: begin
          if (phase_end(r.tcnt, PROG_DELAY_T, tick)) begin
            r_nxt.state = S_SYNC;
            r_nxt.tcnt  = '0;
          end
        end
        S_SYNC: begin
          if (phase_end(r.tcnt, SYNC_T, tick)) begin
            r_nxt.state = S_WDLY;
            r_nxt.tcnt  = '0;
          end
        end
        S_WDLY: begin
          r_nxt.seen0 = 1'b0;
          if (phase_end(r.tcnt, WIN_DELAY_T, tick)) begin
            r_nxt.state = S_WIN;
            r_nxt.tcnt  = '0;
          end
        end
        S_WIN: begin
          r_nxt.seen0 = r.seen0 | line_low;
          if (phase_end(r.tcnt, WIN_LEN_T, tick)) begin
            r_nxt.shift[r.bitn] = !(r.seen0 | line_low);
            r_nxt.state         = S_REST;
            r_nxt.tcnt          = '0;
          end
        end
        S_REST: begin
          if (phase_end(r.tcnt, REST_T, tick)) begin
            r_nxt.tcnt = '0;
            if (r.bitn == WORD_LAST) begin
              r_nxt.eq    = (r.shift == r.mode);
              r_nxt.mode  = r.shift;
              r_nxt.poll  = r.shift[0];
              r_nxt.state = S_EQDLY;
            end else begin
              r_nxt.bitn  = r.bitn + 4'h1;
              r_nxt.state = S_SYNC;
            end
          end
        end
        S_EQDLY: begin
          if (phase_end(r.tcnt, ACK_DELAY_T, tick)) begin
            r_nxt.state = S_ACK;
            r_nxt.tcnt  = '0;
          end
        end
        S_ACK: begin
          if (phase_end(r.tcnt, ACK_T, tick)) begin
            r_nxt.state = S_EQREST;
            r_nxt.tcnt  = '0;
          end
        end
        S_EQREST: begin
          if (phase_end(r.tcnt, EQ_REST_T, tick)) begin
            r_nxt.state = S_IDLE;
            r_nxt.tcnt  = '0;
          end
        end
      endcase
    end

    r_nxt.rx_off  = r_nxt.state != S_IDLE;
    r_nxt.line.o  = 1'b0;
    r_nxt.line.oe = (r_nxt.state == S_SYNC) ||
                    (r_nxt.state == S_ACK && r_nxt.eq) ||
                    (r_nxt.state == S_IDLE && r_nxt.marker &&
                     !r_nxt.por && r_nxt.mph);
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      r         <= '0;
      r.state   <= S_IDLE;
      r.por     <= 1'b1;
      r.marker  <= 1'b1;
      r.mode    <= MODE_DEFAULT;
      r.lim_min <= LIM_MIN_DEFAULT;
      r.lim_max <= LIM_MAX_DEFAULT;
    end else begin
      r <= r_nxt;
    end
  end

  assign RDATA      = r.rdata;
  assign DATA_DRV   = r.line;
  assign RX_OFF     = r.rx_off;
  assign POLL_CMD   = r.poll;
  assign MODE_WORD  = r.mode;
  assign LIM_MIN    = r.lim_min;
  assign LIM_MAX    = r.lim_max;
  assign MARKER_ON  = r.marker;
  assign POR_ACTIVE = r.por;

  property p_por_defaults;
    @(posedge CLOCK) disable iff (!RST_N)
    r.por |=> (MODE_WORD == MODE_DEFAULT && LIM_MIN == LIM_MIN_DEFAULT &&
               LIM_MAX == LIM_MAX_DEFAULT && MARKER_ON);
  endproperty
  a_por_defaults: assert property (p_por_defaults)
    else $error("defaults not loaded during power-on reset");

  property p_por_hold;
    @(posedge CLOCK) disable iff (!RST_N)
    $fell(r.por) |-> ($past(r.pcnt) == RST_PERIOD_T
                      && $past(tick) && $past(supply_lvl));
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("reset released before its hold period");

  property p_drive_cause;
    @(posedge CLOCK) disable iff (!RST_N)
    DATA_DRV.oe |-> (r.state == S_SYNC || (r.state == S_ACK && r.eq) ||
                     (r.state == S_IDLE && r.marker && r.mph && !r.por));
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("data line driven without cause");

  property p_marker_half;
    @(posedge CLOCK) disable iff (!RST_N)
    ($changed(r.mph) && !r.por && $past(r.marker) && !$past(r.por) &&
     $past(r.state) == S_IDLE && r.state == S_IDLE)
    |-> $past(r.pcnt) == swc_cnt_t'(MARKER_HALF_TICKS - 14'h0001);
  endproperty
  a_marker_half: assert property (p_marker_half)
    else $error("marker half period wrong");

  property p_long_start;
    @(posedge CLOCK) disable iff (!RST_N)
    (r.state == S_IDLE && !r_nxt.por && r.was_low && !line_low && long_rel)
    |=> (!MARKER_ON && r.state == S_DELAY && MODE_WORD == MODE_DEFAULT);
  endproperty
  a_long_start: assert property (p_long_start)
    else $error("long start pulse not handled");

  property p_short_in_reset;
    @(posedge CLOCK) disable iff (!RST_N)
    (r.state == S_IDLE && r.marker && !r_nxt.por && r.was_low &&
     !line_low && short_rel) |=> (r.state == S_IDLE && MARKER_ON);
  endproperty
  a_short_in_reset: assert property (p_short_in_reset)
    else $error("short start pulse acted on while marker runs");

  property p_sync_len;
    @(posedge CLOCK) disable iff (!RST_N)
    $fell(r.state == S_SYNC) |->
      ($past(r.tcnt) == swc_cnt_t'(SYNC_T - 14'h0001) && $past(tick));
  endproperty
  a_sync_len: assert property (p_sync_len)
    else $error("sync pulse length wrong");

  property p_fifteen_bits;
    @(posedge CLOCK) disable iff (!RST_N)
    $rose(r.state == S_EQDLY) |-> ($past(r.bitn) == WORD_LAST &&
                                   $past(r.state) == S_REST);
  endproperty
  a_fifteen_bits: assert property (p_fifteen_bits)
    else $error("equivalence window not after fifteenth bit");

  property p_bit_store;
    @(posedge CLOCK) disable iff (!RST_N)
    ($past(r.state) == S_WIN && r.state == S_REST) |->
      r.shift[$past(r.bitn)] == !($past(r.seen0) | $past(line_low));
  endproperty
  a_bit_store: assert property (p_bit_store)
    else $error("sampled bit stored wrongly");

  property p_commit;
    @(posedge CLOCK) disable iff (!RST_N)
    $rose(r.state == S_EQDLY) |-> (MODE_WORD == $past(r.shift) &&
      r.eq == ($past(r.shift) == $past(r.mode)) && POLL_CMD == MODE_WORD[0]);
  endproperty
  a_commit: assert property (p_commit)
    else $error("mode word commit or compare wrong");

  property p_rx_off;
    @(posedge CLOCK) disable iff (!RST_N)
    $rose(r.state == S_DELAY) |-> RX_OFF ##1 RX_OFF;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receive path not disabled while programming");

endmodule : swc_config_port

`default_nettype wire

/* File: design/swc_pin_sync.sv */
/*
 * Three-stage synchroniser for an asynchronous pin; the output moves
 * only once stages two and three agree. Assumes an idle-high pin.
 */
`timescale 1ns/1ps
`default_nettype none

module swc_pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output var  logic lvl
);
  import swc_pkg::*;

  swc_sync_t r;
  swc_sync_t r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = pin;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    if (r.s2 == r.s3) begin
      r_nxt.lvl = r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= 4'hf;
    end else begin
      r <= r_nxt;
    end
  end

  assign lvl = r.lvl;

endmodule : swc_pin_sync

`default_nettype wire

/* File: design/swc_pkg.sv */
/*
 * Constants, field layouts, types and timing counts of the single-wire
 * configuration port. Assumes a 10 MHz system clock; all protocol times
 * are counted in base clock periods made by a divider.
 */
`default_nettype none

package swc_pkg;

  // system clock and derived base clock
  localparam int CLK_PERIOD_NS  = 100;
  localparam int BASE_PERIOD_NS = 2000;
  localparam int BASE_DIV       = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

  typedef logic [13:0] swc_cnt_t;
  typedef logic [4:0]  swc_div_cnt_t;

  // start pulse classes, in base periods (5632, 7936)
  localparam swc_cnt_t SHORT_START_T = 14'h1600;
  localparam swc_cnt_t LONG_START_T  = 14'h1f00;
  localparam swc_cnt_t START_MIN_T   = 14'h0040;
  // programming sequence, in base periods
  localparam swc_cnt_t PROG_DELAY_T  = 14'h0010;
  localparam swc_cnt_t SYNC_T        = 14'h0008;
  localparam swc_cnt_t WIN_DELAY_T   = 14'h0008;
  localparam swc_cnt_t WIN_LEN_T     = 14'h0020;
  localparam swc_cnt_t FRAME_T       = 14'h0040;
  localparam swc_cnt_t REST_T        = swc_cnt_t'(FRAME_T - SYNC_T
                                       - WIN_DELAY_T - WIN_LEN_T);
  localparam swc_cnt_t EQ_WIN_T      = 14'h0040;
  localparam swc_cnt_t ACK_DELAY_T   = 14'h0008;
  localparam swc_cnt_t ACK_T         = 14'h0010;
  localparam swc_cnt_t EQ_REST_T     = swc_cnt_t'(EQ_WIN_T - ACK_DELAY_T
                                       - ACK_T);
  // reset hold and marker half period (2048 periods, about 122 Hz)
  localparam swc_cnt_t RST_PERIOD_T  = 14'h0020;
  localparam swc_cnt_t MARKER_HALF_T = 14'h0800;

  // mode word: bit 1 of the transfer sits at index 0
  typedef logic [14:0] swc_word_t;
  localparam logic [3:0] WORD_LAST   = 4'he;
  localparam int         SLEEP_LSB   = 1;
  localparam int         XSLEEP_BIT  = 6;
  // sleep count 6, extension factor 1
  localparam swc_word_t  MODE_DEFAULT = 15'h000c;

  typedef logic [5:0] swc_lim_t;
  localparam swc_lim_t LIM_MIN_DEFAULT = 6'h15;
  localparam swc_lim_t LIM_MAX_DEFAULT = 6'h29;
  localparam int       LIM_MAX_LSB     = 6;

  // register map
  typedef logic [3:0] swc_addr_t;
  localparam swc_addr_t REG_MODE   = 4'h0;
  localparam swc_addr_t REG_LIMIT  = 4'h4;
  localparam swc_addr_t REG_STATUS = 4'h8;
  localparam int ST_POR    = 0;
  localparam int ST_MARKER = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_EQUAL  = 3;

  typedef enum logic [3:0] {
    S_IDLE, S_DELAY, S_SYNC, S_WDLY, S_WIN, S_REST, S_EQDLY, S_ACK, S_EQREST
  } swc_state_t;

  typedef struct packed {
    logic oe;
    logic o;
  } swc_line_t;

  typedef struct packed {
    swc_state_t  state;
    swc_cnt_t    tcnt;
    swc_cnt_t    lowcnt;
    swc_cnt_t    pcnt;
    logic [3:0]  bitn;
    swc_word_t   shift;
    swc_word_t   mode;
    swc_lim_t    lim_min;
    swc_lim_t    lim_max;
    logic        por;
    logic        marker;
    logic        mph;
    logic        was_low;
    logic        seen0;
    logic        eq;
    logic        poll;
    logic        rx_off;
    swc_line_t   line;
    logic [31:0] rdata;
  } swc_regs_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } swc_sync_t;

  typedef struct packed {
    swc_div_cnt_t cnt;
    logic         tick;
  } swc_div_t;

endpackage : swc_pkg

`default_nettype wire

/* File: tb/swc_config_port_bench.sv */
/*
 * Self-checking bench of the configuration port: reset defaults, marker,
 * register port, start pulses of each class and supply loss.
 * Assumes the host model on a pulled-up line and the package timing.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("mismatch %s expected %0h seen %0h", nm, (e), (g)); \
  end \
end

module swc_config_port_bench;
  import swc_pkg::*;
  localparam int TB = BASE_DIV;
  localparam swc_cnt_t LONG_T  = 14'h0190;
  localparam swc_cnt_t SHORT_T = 14'h00c8;
  localparam swc_cnt_t HALF_T  = 14'h0028;

  logic        CLOCK, RST_N, SUPPLY_OK, WR, RD, host_pull;
  swc_addr_t   ADDR;
  logic [31:0] WDATA, RDATA;
  swc_line_t   DATA_DRV;
  logic        RX_OFF, POLL_CMD, MARKER_ON, POR_ACTIVE;
  swc_word_t   MODE_WORD;
  swc_lim_t    LIM_MIN, LIM_MAX;
  wire logic   line;
  int          fails = 0, compares = 0, poll_cnt = 0, seed = 91;

  assign line = ((DATA_DRV.oe && !DATA_DRV.o) || host_pull) ? 1'b0 : 1'b1;
  always #50 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (POLL_CMD === 1'b1) poll_cnt <= poll_cnt + 1;

  swc_config_port #(
    .SHORT_START_TICKS(SHORT_T),
    .LONG_START_TICKS (LONG_T),
    .MARKER_HALF_TICKS(HALF_T)
  ) uut (
    .CLOCK(CLOCK), .RST_N(RST_N), .DATA_I(line), .SUPPLY_OK(SUPPLY_OK),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .DATA_DRV(DATA_DRV), .RX_OFF(RX_OFF), .POLL_CMD(POLL_CMD),
    .MODE_WORD(MODE_WORD), .LIM_MIN(LIM_MIN), .LIM_MAX(LIM_MAX),
    .MARKER_ON(MARKER_ON), .POR_ACTIVE(POR_ACTIVE)
  );

  swc_host_model host (.clk(CLOCK), .line(line), .pull(host_pull));

  function automatic logic [31:0] status_of(input logic por, mk, bsy, eq);
    return {28'h0, eq, bsy, mk, por};
  endfunction : status_of

  function automatic logic [31:0] limit_of(input swc_lim_t mx, mn);
    return {20'h0, mx, mn};
  endfunction : limit_of

  task automatic wr(input swc_addr_t a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input swc_addr_t a, input logic [31:0] e);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    `CHK("rdata", e, RDATA)
  endtask : rd

  task automatic por_wait();
    int n;
    n = 0;
    while (POR_ACTIVE !== 1'b0 && n < 5000) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    `CHK("por_hold", 1'b1, (n >= RST_PERIOD_T * TB) && (n < 5000))
  endtask : por_wait

  task automatic run_len(input logic v, output int n);
    n = 0;
    while (DATA_DRV.oe === v && n < 4000) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
  endtask : run_len

  task automatic prog(input int t, input swc_word_t w, input logic ea);
    logic ack;
    int   ns, bad, n;
    fork
      host.transfer(t, w, ack, ns, bad);
      begin
        repeat ((t + 40) * TB) @(posedge CLOCK);
        `CHK("rx_off", 1'b1, RX_OFF)
      end
    join
    `CHK("sync_count", 15, ns)
    `CHK("frame_timing", 0, bad)
    `CHK("ack", ea, ack)
    n = 0;
    while (RX_OFF !== 1'b0 && n < 3000) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    `CHK("rx_off_end", 1'b1, n < 3000)
    repeat (2) @(posedge CLOCK);
    `CHK("mode_word", w, MODE_WORD)
  endtask : prog

  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // whole run is about 60000 cycles
  initial begin
    repeat (90000) @(posedge CLOCK);
    fails++;
    conclude();
  end

  initial begin
    int        hi, lo;
    swc_lim_t  lmn, lmx;
    swc_word_t w;
    CLOCK = 1'b0;
    RST_N = 1'b0;
    SUPPLY_OK = 1'b1;
    ADDR = '0;
    WDATA = '0;
    WR = 1'b0;
    RD = 1'b0;
    repeat (12) @(posedge CLOCK);
    RST_N <= 1'b1;
    #1;
    `CHK("mode_dflt", MODE_DEFAULT, MODE_WORD)
    `CHK("lim_min_dflt", 6'h15, LIM_MIN)
    `CHK("lim_max_dflt", 6'h29, LIM_MAX)
    `CHK("marker_rst", 1'b1, MARKER_ON)
    por_wait();
    rd(REG_STATUS, status_of(1'b0, 1'b1, 1'b0, 1'b0));
    for (int i = 0; i < 2; i++) begin
      run_len(1'b1, hi);
      run_len(1'b0, lo);
    end
    `CHK("marker_half", HALF_T * TB, hi)
    `CHK("marker_duty", HALF_T * TB, lo)
    lmn = swc_lim_t'($random(seed));
    lmx = swc_lim_t'($random(seed));
    wr(REG_LIMIT, limit_of(lmx, lmn));
    rd(REG_LIMIT, limit_of(lmx, lmn));
    `CHK("lim_max", lmx, LIM_MAX)
    wr(REG_MODE, $random(seed));
    rd(REG_MODE, {17'h0, MODE_DEFAULT});
    rd(4'hc, 32'h0);
    // short pulse while the marker runs
    host.align();
    host.start_pulse(100);
    repeat (40 * TB) @(posedge CLOCK);
    `CHK("short_ignored", 1'b0, RX_OFF)
    `CHK("marker_kept", 1'b1, MARKER_ON)
    w = swc_word_t'($random(seed)) | 15'h0001;
    host.align();
    prog(420, w, 1'b0);
    `CHK("marker_cleared", 1'b0, MARKER_ON)
    `CHK("lim_reload", LIM_MIN_DEFAULT, LIM_MIN)
    `CHK("poll_first", 1, poll_cnt)
    prog(100, w, 1'b1);
    `CHK("poll_second", 2, poll_cnt)
    rd(REG_STATUS, status_of(1'b0, 1'b0, 1'b0, 1'b1));
    @(posedge CLOCK);
    SUPPLY_OK <= 1'b0;
    repeat (10) @(posedge CLOCK);
    #1;
    `CHK("por_again", 1'b1, POR_ACTIVE)
    `CHK("mode_reload", MODE_DEFAULT, MODE_WORD)
    `CHK("marker_again", 1'b1, MARKER_ON)
    @(posedge CLOCK);
    SUPPLY_OK <= 1'b1;
    por_wait();
    conclude();
  end
endmodule : swc_config_port_bench

`default_nettype wire

/* File: tb/swc_host_model.sv */
/*
 * Host controller model on the shared open-drain data line.
 * Assumes an idle-high pulled-up line and the package timing counts.
 */
`timescale 1ns/1ps
`default_nettype none

module swc_host_model #(
  parameter int ZERO_TICKS = 8
) (
  input  wire logic clk,
  input  wire logic line,
  output var  logic pull
);
  import swc_pkg::*;
  localparam int TB = BASE_DIV;
  int unsigned cyc = 0;

  initial pull = 1'b0;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic wait_level(input logic lv, input int lim, output int n);
    n = 0;
    while (line !== lv && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_level

  // start on a released marker phase so the line really rises at release
  task automatic align();
    int n;
    wait_level(1'b0, 2000, n);
    wait_level(1'b1, 2000, n);
  endtask : align

  task automatic start_pulse(input int ticks);
    @(posedge clk);
    pull <= 1'b1;
    repeat (ticks * TB) @(posedge clk);
    pull <= 1'b0;
  endtask : start_pulse

  task automatic transfer(input int ticks, input swc_word_t w,
                          output logic ack, output int nsync,
                          output int bad);
    int          n;
    int unsigned last;
    nsync = 0;
    bad = 0;
    ack = 1'b0;
    last = 0;
    start_pulse(ticks);
    @(posedge clk);
    for (int k = 0; k < 15; k++) begin
      wait_level(1'b0, 4000, n);
      if (line !== 1'b0) break;
      if (k > 0 && (cyc - last) != FRAME_T * TB) bad++;
      last = cyc;
      nsync++;
      wait_level(1'b1, 400, n);
      if (n != SYNC_T * TB) bad++;
      repeat ((WIN_DELAY_T + 8) * TB) @(posedge clk);
      if (!w[k]) begin
        pull <= 1'b1;
        repeat (ZERO_TICKS * TB) @(posedge clk);
        pull <= 1'b0;
      end
      @(posedge clk);
    end
    wait_level(1'b0, (REST_T + EQ_WIN_T) * TB, n);
    if (line === 1'b0) begin
      ack = 1'b1;
      wait_level(1'b1, 1000, n);
      if (n != ACK_T * TB) bad++;
    end
  endtask : transfer
endmodule : swc_host_model

`default_nettype wire
